// File: src/waveform_noload_config_params.svh
/*
 Constants for the waveform and no-load configuration block: register
 addresses, field positions, reset values, divider and threshold figures.
 Assumes inclusion by bare name from the block's module and its bench.
*/
`ifndef WAVEFORM_NOLOAD_CONFIG_PARAMS_SVH
`define WAVEFORM_NOLOAD_CONFIG_PARAMS_SVH

`define WAVE_CFG_ADDR 8'h0D
`define NOLOAD_CFG_ADDR 8'h0E
`define STATUS_ADDR 8'h10
`define CFG_RESET 8'h00
`define RD_IDLE 8'h00

`define SRC2_MSB 7
`define SRC2_LSB 5
`define SRC1_MSB 4
`define SRC1_LSB 2
`define RATE_MSB 1
`define RATE_LSB 0

`define COMP_DIS_BIT 7
`define IRMS_NL_BIT 6
`define VA_NL_MSB 5
`define VA_NL_LSB 4
`define VAR_NL_MSB 3
`define VAR_NL_LSB 2
`define AP_NL_MSB 1
`define AP_NL_LSB 0

`define ST_DUE_BIT 0
`define ST_VALID_BIT 1
`define ST_NL_LSB 2
`define ST_NL_MSB 5

`define PRESCALE_LAST 3'h4
`define PRESCALE_DIV 12'h005
`define RATE_LAST_32 8'h1F
`define RATE_LAST_64 8'h3F
`define RATE_LAST_128 8'h7F
`define RATE_LAST_256 8'hFF

`define NL_OFF 2'h0
`define NL_LVL1 2'h1
`define NL_LVL2 2'h2
`define THR_0300 24'h0013A9
`define THR_0150 24'h0009D5
`define THR_0075 24'h0004EA
`define THR_0037 24'h00026D

`endif

// File: src/waveform_noload_pkg.sv
/*
 Types shared by the waveform and no-load configuration block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package waveform_noload_pkg;
	typedef logic [23:0] sample_t;
	typedef logic [47:0] pair_t;
	typedef enum logic [2:0] {
		SRC_CURRENT,
		SRC_VOLTAGE,
		SRC_ACTIVE,
		SRC_REACTIVE,
		SRC_APPARENT,
		SRC_IRMS
	} wave_src_e;
endpackage : waveform_noload_pkg

// File: src/wave_buf_if.sv
/*
 Valid/ready carrier between the sampler and its two-entry buffer.
 Assumes both ends run on one clock.
*/
`timescale 1ns/1ps
interface wave_buf_if;
	logic inValid;
	logic inReady;
	waveform_noload_pkg::pair_t inData;
	logic outValid;
	logic outReady;
	waveform_noload_pkg::pair_t outData;
	modport buffer (input inValid, inData, outReady,
		output inReady, outValid, outData);
	modport user (output inValid, inData, outReady,
		input inReady, outValid, outData);
endinterface : wave_buf_if

// File: src/wave_skid_buffer.sv
/*
 Two-entry skid buffer for waveform sample pairs; output side registered.
 Assumes a synchronous active-high reset and one clock.
*/
`timescale 1ns/1ps
module wave_skid_buffer (
	input wire logic core_clk,
	input wire logic srst,
	wave_buf_if.buffer bus
);
	logic outValid_q;
	logic skidValid_q;
	waveform_noload_pkg::pair_t outData_q;
	waveform_noload_pkg::pair_t skidData_q;

	// ready depends only on a flop, so no path from outReady to inReady
	assign bus.inReady = !skidValid_q;
	assign bus.outValid = outValid_q;
	assign bus.outData = outData_q;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			outValid_q <= 1'b0;
			skidValid_q <= 1'b0;
			outData_q <= '0;
			skidData_q <= '0;
		end else if (bus.outReady || !outValid_q) begin
			if (skidValid_q) begin
				outValid_q <= 1'b1;
				outData_q <= skidData_q;
				skidValid_q <= 1'b0;
			end else begin
				outValid_q <= bus.inValid;
				outData_q <= bus.inData;
			end
		end else if (bus.inValid && !skidValid_q) begin
			skidValid_q <= 1'b1;
			skidData_q <= bus.inData;
		end
	end

	a_buf_hold_stall: assert property (@(posedge core_clk) disable iff (srst)
		outValid_q && !bus.outReady |=> outValid_q && $stable(outData_q))
		else $error("buffer output changed while stalled");
endmodule : wave_skid_buffer

// File: src/waveform_noload_config.sv
/*
 Waveform source/rate and no-load configuration registers with the
 sampler and no-load detectors they steer.
 Assumes a simple strobe register port with read data one cycle later,
 synchronous measurement inputs, and magnitudes as unsigned 24-bit values.
*/
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "waveform_noload_config_params.svh"
module waveform_noload_config (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic waveEnable,
	input wire waveform_noload_pkg::sample_t currentSample,
	input wire waveform_noload_pkg::sample_t voltageSample,
	input wire waveform_noload_pkg::sample_t activeMult,
	input wire waveform_noload_pkg::sample_t reactiveMult,
	input wire waveform_noload_pkg::sample_t apparentMult,
	input wire logic [31:0] irmsLpf,
	input wire waveform_noload_pkg::sample_t activeMag,
	input wire waveform_noload_pkg::sample_t reactiveMag,
	input wire waveform_noload_pkg::sample_t apparentMag,
	input wire waveform_noload_pkg::sample_t irmsMag,
	input wire logic waveReady,
	output logic waveValid,
	output waveform_noload_pkg::sample_t waveOneData,
	output waveform_noload_pkg::sample_t waveTwoData,
	output logic reactiveCompEnable,
	output logic activeNoLoad,
	output logic reactiveNoLoad,
	output logic apparentNoLoad,
	output logic current_rms_noload_enable
);
	logic [7:0] waveCfg_q;
	logic [7:0] noLoadCfg_q;
	logic [7:0] regRdData_q;
	logic [2:0] preCnt_q;
	logic [7:0] tickCnt_q;
	logic sampleDue_q;
	waveform_noload_pkg::sample_t capOne_q;
	waveform_noload_pkg::sample_t capTwo_q;
	logic compEnable_q;
	logic [3:0] noLoad_q;
	logic tick;
	logic [7:0] rateLast;
	logic rateHit;
	logic accept;
	logic wrWave;
	logic wrNoLoad;
	wave_buf_if bufIf ();

	assign wrWave = regWr && (regAddr == `WAVE_CFG_ADDR);
	assign wrNoLoad = regWr && (regAddr == `NOLOAD_CFG_ADDR);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			waveCfg_q <= `CFG_RESET;
		end else if (wrWave) begin
			waveCfg_q <= regWrData;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			noLoadCfg_q <= `CFG_RESET;
		end else if (wrNoLoad) begin
			noLoadCfg_q <= regWrData;
		end
	end

	// unmapped reads answer zero; data stands one cycle only
	always_ff @(posedge core_clk) begin
		if (srst || !regRd) begin
			regRdData_q <= `RD_IDLE;
		end else begin
			case (regAddr)
				`WAVE_CFG_ADDR: regRdData_q <= waveCfg_q;
				`NOLOAD_CFG_ADDR: regRdData_q <= noLoadCfg_q;
				`STATUS_ADDR: begin
					regRdData_q <= `RD_IDLE;
					regRdData_q[`ST_DUE_BIT] <= sampleDue_q;
					regRdData_q[`ST_VALID_BIT] <= bufIf.outValid;
					regRdData_q[`ST_NL_MSB:`ST_NL_LSB] <= noLoad_q;
				end
				default: regRdData_q <= `RD_IDLE;
			endcase
		end
	end

	assign tick = (preCnt_q == `PRESCALE_LAST);
	always_ff @(posedge core_clk) begin
		if (srst || tick) begin
			preCnt_q <= 3'h0;
		end else begin
			preCnt_q <= preCnt_q + 3'h1;
		end
	end

	always_comb begin
		case (waveCfg_q[`RATE_MSB:`RATE_LSB])
			2'h0: rateLast = `RATE_LAST_32;
			2'h1: rateLast = `RATE_LAST_64;
			2'h2: rateLast = `RATE_LAST_128;
			default: rateLast = `RATE_LAST_256;
		endcase
	end

	assign rateHit = waveEnable && tick && (tickCnt_q >= rateLast);
	// >= so that lowering the rate mid-count cannot run past the end
	always_ff @(posedge core_clk) begin
		if (srst || !waveEnable) begin
			tickCnt_q <= 8'h00;
		end else if (tick) begin
			tickCnt_q <= (tickCnt_q >= rateLast) ? 8'h00 : tickCnt_q + 8'h01;
		end
	end

	function automatic waveform_noload_pkg::sample_t pickTwo(
		input logic [2:0] code
	);
		case (code)
			waveform_noload_pkg::SRC_CURRENT: pickTwo = currentSample;
			waveform_noload_pkg::SRC_VOLTAGE: pickTwo = voltageSample;
			waveform_noload_pkg::SRC_ACTIVE: pickTwo = activeMult;
			waveform_noload_pkg::SRC_REACTIVE: pickTwo = reactiveMult;
			waveform_noload_pkg::SRC_APPARENT: pickTwo = apparentMult;
			waveform_noload_pkg::SRC_IRMS: pickTwo = irmsLpf[31:8];
			default: pickTwo = '0;
		endcase
	endfunction : pickTwo

	// wave one mux, low rms bits
	function automatic waveform_noload_pkg::sample_t pickOne(
		input logic [2:0] code
	);
		case (code)
			waveform_noload_pkg::SRC_CURRENT: pickOne = currentSample;
			waveform_noload_pkg::SRC_VOLTAGE: pickOne = voltageSample;
			waveform_noload_pkg::SRC_ACTIVE: pickOne = activeMult;
			waveform_noload_pkg::SRC_REACTIVE: pickOne = reactiveMult;
			waveform_noload_pkg::SRC_APPARENT: pickOne = apparentMult;
			waveform_noload_pkg::SRC_IRMS: pickOne = irmsLpf[23:0];
			default: pickOne = '0;
		endcase
	endfunction : pickOne

	// a stalled pair is overwritten by the newer one: freshest data wins
	always_ff @(posedge core_clk) begin
		if (srst) begin
			capOne_q <= '0;
			capTwo_q <= '0;
		end else if (rateHit) begin
			capOne_q <= pickOne(waveCfg_q[`SRC1_MSB:`SRC1_LSB]);
			capTwo_q <= pickTwo(waveCfg_q[`SRC2_MSB:`SRC2_LSB]);
		end
	end

	assign accept = sampleDue_q && bufIf.inReady;
	// new sample wins over hand-off in the same cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sampleDue_q <= 1'b0;
		end else if (rateHit) begin
			sampleDue_q <= 1'b1;
		end else if (accept) begin
			sampleDue_q <= 1'b0;
		end
	end

	assign bufIf.inValid = sampleDue_q;
	assign bufIf.inData = {capOne_q, capTwo_q};
	assign bufIf.outReady = waveReady;

	wave_skid_buffer buffer (
		.core_clk(core_clk),
		.srst(srst),
		.bus(bufIf.buffer)
	);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			compEnable_q <= 1'b1;
		end else begin
			compEnable_q <= !noLoadCfg_q[`COMP_DIS_BIT];
		end
	end

	// 0 active, 1 reactive, 2 apparent, 3 rms current
	waveform_noload_pkg::sample_t nlMag [4];
	logic [1:0] nlCode [4];
	assign nlMag[0] = activeMag;
	assign nlMag[1] = reactiveMag;
	assign nlMag[2] = apparentMag;
	assign nlMag[3] = irmsMag;
	assign nlCode[0] = noLoadCfg_q[`AP_NL_MSB:`AP_NL_LSB];
	assign nlCode[1] = noLoadCfg_q[`VAR_NL_MSB:`VAR_NL_LSB];
	assign nlCode[2] = noLoadCfg_q[`VA_NL_MSB:`VA_NL_LSB];
	assign nlCode[3] = noLoadCfg_q[`IRMS_NL_BIT] ?
		noLoadCfg_q[`VA_NL_MSB:`VA_NL_LSB] : `NL_OFF;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_noload
			waveform_noload_pkg::sample_t thr;
			always_comb begin
				if (gi >= 2) begin
					case (nlCode[gi])
						`NL_LVL1: thr = `THR_0300;
						`NL_LVL2: thr = `THR_0150;
						default: thr = `THR_0075;
					endcase
				end else begin
					case (nlCode[gi])
						`NL_LVL1: thr = `THR_0150;
						`NL_LVL2: thr = `THR_0075;
						default: thr = `THR_0037;
					endcase
				end
			end
			always_ff @(posedge core_clk) begin
				if (srst) begin
					noLoad_q[gi] <= 1'b0;
				end else begin
					noLoad_q[gi] <= (nlCode[gi] != `NL_OFF) &&
						(nlMag[gi] < thr);
				end
			end
		end
	endgenerate

	assign regRdData = regRdData_q;
	assign waveValid = bufIf.outValid;
	assign waveOneData = bufIf.outData[47:24];
	assign waveTwoData = bufIf.outData[23:0];
	assign reactiveCompEnable = compEnable_q;
	assign activeNoLoad = noLoad_q[0];
	assign reactiveNoLoad = noLoad_q[1];
	assign apparentNoLoad = noLoad_q[2];
	assign current_rms_noload_enable = noLoad_q[3];

	// helper: cycles between pacing hits at an unchanged rate
	logic [11:0] gapCnt_q;
	logic hitSeen_q;
	logic rateSame_q;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			gapCnt_q <= 12'h000;
			hitSeen_q <= 1'b0;
			rateSame_q <= 1'b0;
		end else begin
			gapCnt_q <= rateHit ? 12'h000 :
				(gapCnt_q == 12'hFFF ? gapCnt_q : gapCnt_q + 12'h001);
			hitSeen_q <= waveEnable && (hitSeen_q || rateHit);
			rateSame_q <= !wrWave && (rateSame_q || rateHit);
		end
	end

	a_wave_two_voltage:
	assert property (@(posedge core_clk) disable iff (srst)
		rateHit && waveCfg_q[`SRC2_MSB:`SRC2_LSB] == 3'h1
		|=> capTwo_q == $past(voltageSample))
		else $error("wave two did not take voltage");

	a_wave_one_irms:
	assert property (@(posedge core_clk) disable iff (srst)
		rateHit && waveCfg_q[`SRC1_MSB:`SRC1_LSB] == 3'h5
		|=> ##1 bufIf.inData[47:24] == $past(irmsLpf[23:0], 2))
		else $error("wave one did not take low rms bits");

	a_rate_period:
	assert property (@(posedge core_clk) disable iff (srst)
		rateHit && hitSeen_q && rateSame_q |->
		gapCnt_q == 12'(({4'h0, rateLast} + 12'h001) * `PRESCALE_DIV
		- 12'h001))
		else $error("sample pacing period wrong");

	a_comp_follows:
	assert property (@(posedge core_clk) disable iff (srst)
		wrNoLoad |=> ##1 reactiveCompEnable ==
		!$past(regWrData[`COMP_DIS_BIT], 2))
		else $error("compensation switch not following bit 7");

	a_irms_gate:
	assert property (@(posedge core_clk) disable iff (srst)
		!noLoadCfg_q[`IRMS_NL_BIT] |=> !current_rms_noload_enable)
		else $error("rms no-load flagged while disabled");

	a_apparent_lvl1:
	assert property (@(posedge core_clk) disable iff (srst)
		noLoadCfg_q[`VA_NL_MSB:`VA_NL_LSB] == 2'h1 &&
		apparentMag == 24'h0013A8 |=> apparentNoLoad)
		else $error("apparent no-load missed at 0.030 percent");

	a_reactive_lvl3:
	assert property (@(posedge core_clk) disable iff (srst)
		noLoadCfg_q[`VAR_NL_MSB:`VAR_NL_LSB] == 2'h3 &&
		reactiveMag == 24'h00026D |=> !reactiveNoLoad)
		else $error("reactive no-load threshold too high");

	a_active_off:
	assert property (@(posedge core_clk) disable iff (srst)
		noLoadCfg_q[`AP_NL_MSB:`AP_NL_LSB] == 2'h0 |=> !activeNoLoad)
		else $error("active no-load flagged while disabled");

	a_enable_gate:
	assert property (@(posedge core_clk) disable iff (srst)
		!waveEnable && !sampleDue_q |=> !sampleDue_q)
		else $error("sample produced while sampling disabled");

	a_active_suppress:
	assert property (@(posedge core_clk) disable iff (srst)
		noLoadCfg_q[`AP_NL_MSB:`AP_NL_LSB] == 2'h2 &&
		activeMag == 24'h000000 |=> activeNoLoad)
		else $error("zero active power not suppressed");

	a_read_latency:
	assert property (@(posedge core_clk) disable iff (srst)
		regRd && regAddr == `WAVE_CFG_ADDR && !regWr
		|=> regRdData == $past(waveCfg_q))
		else $error("read data not the register value");
endmodule : waveform_noload_config

// File: bench/waveform_noload_config_tb_top.sv
/*
 Self-checking bench for the waveform and no-load configuration block.
 Assumes the block's header is on the include path, one 100 MHz clock.
*/
`timescale 1ns/1ps
`include "waveform_noload_config_params.svh"
module waveform_noload_config_tb_top;
	typedef struct packed {
		logic [7:0] cfg;
		logic [23:0] a;
		logic [23:0] r;
		logic [23:0] v;
		logic [23:0] i;
		logic [3:0] fl;
		logic comp;
	} row_s;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [7:0] regRdData;
	logic waveEnable = 1'b0;
	logic waveReady = 1'b0;
	logic [31:0] irmsLpf = 32'hA1B2C3D4;
	waveform_noload_pkg::sample_t activeMag = 24'h000000;
	waveform_noload_pkg::sample_t reactiveMag = 24'h000000;
	waveform_noload_pkg::sample_t apparentMag = 24'h000000;
	waveform_noload_pkg::sample_t irmsMag = 24'h000000;
	logic waveValid;
	waveform_noload_pkg::sample_t waveOneData;
	waveform_noload_pkg::sample_t waveTwoData;
	logic reactiveCompEnable;
	logic activeNoLoad;
	logic reactiveNoLoad;
	logic apparentNoLoad;
	logic current_rms_noload_enable;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	// thresholds straddled by one count, strict less-than
	row_s rows [6] = '{
		'{8'h00, 24'h0, 24'h0, 24'h0, 24'h0, 4'h0, 1'b1},
		'{8'h80, 24'h0, 24'h0, 24'h0, 24'h0, 4'h0, 1'b0},
		'{8'h15, `THR_0150 - 24'h1, `THR_0150, `THR_0300 - 24'h1,
			24'h0, 4'h5, 1'b1},
		'{8'h6A, `THR_0075 - 24'h1, `THR_0075 - 24'h1, `THR_0150,
			`THR_0150 - 24'h1, 4'hB, 1'b1},
		'{8'h7F, `THR_0037 - 24'h1, `THR_0037, `THR_0075 - 24'h1,
			`THR_0075, 4'h5, 1'b1},
		// rms bit set but apparent code off: rms detection stays off
		'{8'h42, 24'h0, 24'h0, 24'h0, 24'h0, 4'h1, 1'b1}
	};

	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) cyc <= cyc + 1;

	waveform_noload_config dut_u (
		.core_clk(core_clk), .srst(srst), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .waveEnable(waveEnable),
		.currentSample(24'h111111), .voltageSample(24'h222222),
		.activeMult(24'h333333), .reactiveMult(24'h444444),
		.apparentMult(24'h555555), .irmsLpf(irmsLpf),
		.activeMag(activeMag), .reactiveMag(reactiveMag),
		.apparentMag(apparentMag), .irmsMag(irmsMag),
		.waveReady(waveReady), .waveValid(waveValid),
		.waveOneData(waveOneData), .waveTwoData(waveTwoData),
		.reactiveCompEnable(reactiveCompEnable),
		.activeNoLoad(activeNoLoad), .reactiveNoLoad(reactiveNoLoad),
		.apparentNoLoad(apparentNoLoad), .current_rms_noload_enable(current_rms_noload_enable)
	);

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1;
		check(regRdData, exp);
	endtask : rd

	// bounded wait, sampled just after each edge
	task automatic wait_valid(input int bound);
		for (int n = 0; n < bound; n++) begin
			@(posedge core_clk);
			#1;
			if (waveValid === 1'b1) begin
				return;
			end
		end
		error_cnt++;
		$display("wrong value at %0t: no sample pair in time", $time);
		complete_run();
	endtask : wait_valid

	function automatic logic [23:0] src_val(input logic [2:0] c,
		input logic one);
		case (c)
			3'h0: src_val = 24'h111111;
			3'h1: src_val = 24'h222222;
			3'h2: src_val = 24'h333333;
			3'h3: src_val = 24'h444444;
			3'h4: src_val = 24'h555555;
			3'h5: src_val = one ? irmsLpf[23:0] : irmsLpf[31:8];
			default: src_val = 24'h000000;
		endcase
	endfunction : src_val

	initial begin
		int t0;
		int seen;
		logic [2:0] c;
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		#1;
		check(reactiveCompEnable, 1'b1);
		rd(`WAVE_CFG_ADDR, 8'h00);
		rd(`NOLOAD_CFG_ADDR, 8'h00);
		wr(8'h33, 8'hFF);
		rd(8'h33, 8'h00);
		rd(`WAVE_CFG_ADDR, 8'h00);
		for (int k = 0; k < 6; k++) begin
			wr(`NOLOAD_CFG_ADDR, rows[k].cfg);
			activeMag <= rows[k].a;
			reactiveMag <= rows[k].r;
			apparentMag <= rows[k].v;
			irmsMag <= rows[k].i;
			repeat (3) @(posedge core_clk);
			#1;
			check({current_rms_noload_enable, apparentNoLoad, reactiveNoLoad,
				activeNoLoad}, rows[k].fl);
			check(reactiveCompEnable, rows[k].comp);
			rd(`NOLOAD_CFG_ADDR, rows[k].cfg);
		end
		waveEnable <= 1'b1;
		waveReady <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			c = 3'(k);
			wr(`WAVE_CFG_ADDR, {c, c + 3'h1, 2'b00});
			wait_valid(400);
			wait_valid(400);
			check(waveTwoData, src_val(c, 1'b0));
			check(waveOneData, src_val(c + 3'h1, 1'b1));
		end
		// pacing: datapath tick is five core cycles
		for (int r = 0; r < 4; r++) begin
			wr(`WAVE_CFG_ADDR, 8'(r));
			wait_valid(1500);
			wait_valid(1500);
			t0 = cyc;
			wait_valid(1500);
			check(cyc - t0, 5 * (32 << r));
		end
		wr(`WAVE_CFG_ADDR, 8'h00);
		waveEnable <= 1'b0;
		repeat (3) @(posedge core_clk);
		seen = 0;
		repeat (400) begin
			@(posedge core_clk);
			#1;
			if (waveValid !== 1'b0) seen++;
		end
		check(seen, 0);
		// stall past several hits: two buffered plus one pending survive
		waveReady <= 1'b0;
		waveEnable <= 1'b1;
		wait_valid(400);
		seen = 0;
		repeat (800) begin
			@(posedge core_clk);
			#1;
			if (waveValid !== 1'b1 || waveOneData !== 24'h111111) seen++;
		end
		check(seen, 0);
		// status: pending pair, output valid, active flag only
		rd(`STATUS_ADDR, 8'h07);
		waveReady <= 1'b1;
		seen = 0;
		// count before each edge: every valid seen here is a transfer
		repeat (10) begin
			if (waveValid === 1'b1) seen++;
			@(posedge core_clk);
			#1;
		end
		check(seen, 3);
		// reset in mid-run clears the registers again
		wr(`WAVE_CFG_ADDR, 8'hA7);
		wr(`NOLOAD_CFG_ADDR, 8'hC5);
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		#1;
		check({waveValid, reactiveCompEnable}, 2'b01);
		rd(`WAVE_CFG_ADDR, 8'h00);
		rd(`NOLOAD_CFG_ADDR, 8'h00);
		complete_run();
	end
endmodule : waveform_noload_config_tb_top
